// file: rtl/cbs_params.svh
`ifndef CBS_PARAMS_SVH
`define CBS_PARAMS_SVH
`define CBS_CLK_PERIOD_NS   8
`define CBS_ADDR_W          9
`define CBS_DATA_W          16
`define CBS_LAST_BIT        5'd25
`define CBS_WR_FLAG_BIT     5'd9
`define CBS_FIRST_DATA_BIT  5'd11
`define CBS_ADDR_COLOR      9'h002
`define CBS_ADDR_PLL_SRST   9'h008
`define CBS_ADDR_CG_SRST    9'h009
`define CBS_ADDR_PLL_EN     9'h010
`define CBS_ADDR_PLL_CFG    9'h011
`define CBS_ADDR_LINK_CLK   9'h014
`define CBS_ADDR_LOCK_STAT  9'h018
`define CBS_ADDR_LOCK_CFG_A 9'h01a
`define CBS_ADDR_LOCK_CFG_B 9'h01b
`define CBS_ADDR_CLK_MGMT   9'h020
`define CBS_ADDR_BLK_EN     9'h022
`define CBS_ADDR_SEQ_CTRL   9'h0c0
`define CBS_ADDR_STATE      9'h0c1
`define CBS_RST_ASSERTED    16'h0001
`define CBS_RST_ZERO        16'h0000
`define CBS_COLOR_BIT       0
`define CBS_PARALLEL_BIT    1
`define CBS_PLL_BYPASS_VAL  16'h0007
`define CBS_PLL_ON_MASK     16'h0003
`define CBS_LINK_CLK_BIT    0
`define CBS_LOGIC_CLK_BIT   1
`define CBS_8BIT_BIT        3
`define CBS_BLK_EN_BIT      0
`define CBS_SEQ_EN_BIT      0
`define CBS_SHUTTER_LSB     1
`define CBS_SLAVE_BIT       3
`define CBS_CLK_TIMEOUT_NS  1000
`define CBS_CLK_TIMEOUT_CYC (`CBS_CLK_TIMEOUT_NS / `CBS_CLK_PERIOD_NS)
`define CBS_LOCK_EDGES      64
`define CBS_FRAME_NS        2048
`define CBS_FRAME_CYC       (`CBS_FRAME_NS / `CBS_CLK_PERIOD_NS)
`endif

// file: rtl/cbs_pkg.sv
package cbs_pkg;
  typedef enum logic [4:0] {
    ST_LOWPWR = 5'h01,
    ST_SB1    = 5'h02,
    ST_SB2    = 5'h04,
    ST_IDLE   = 5'h08,
    ST_RUN    = 5'h10
  } cbs_state_t;

  typedef enum logic [1:0] {
    SH_PIPELINED = 2'h0,
    SH_TRIGGERED = 2'h1,
    SH_ROLLING   = 2'h2,
    SH_SPARE     = 2'h3
  } cbs_shutter_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
    logic trig;
  } cbs_pins_t;

  typedef struct packed {
    logic [15:0] color;
    logic [15:0] pll_srst;
    logic [15:0] cg_srst;
    logic [15:0] pll_en;
    logic [15:0] pll_cfg;
    logic [15:0] link_clk;
    logic [15:0] lock_a;
    logic [15:0] lock_b;
    logic [15:0] clk_mgmt;
    logic [15:0] blk_en;
    logic [15:0] seq_ctrl;
  } cbs_regs_t;

  typedef struct packed {
    cbs_pins_t   s1;
    cbs_pins_t   s2;
    cbs_pins_t   prev;
    logic [4:0]  bit_cnt;
    logic [24:0] shift;
    logic [15:0] tx;
    logic        miso_oe;
    cbs_regs_t   regs;
    logic [6:0]  lock_cnt;
    logic        locked;
    cbs_state_t  state;
    logic        logic_clk;
    logic        blocks;
    logic        seq;
    logic [8:0]  frame_cnt;
    logic        frame_pulse;
  } cbs_main_t;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    logic [7:0] idle_cnt;
    logic       alive;
    logic       edge_seen;
  } cbs_mon_t;
endpackage : cbs_pkg

// file: rtl/cbs_clk_monitor.sv
`timescale 1ns/1ns
`include "cbs_params.svh"
module cbs_clk_monitor
  import cbs_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic clk_pin_in,
  output logic      edge_out,
  output logic      alive_out
);
  cbs_mon_t mon_reg;
  cbs_mon_t mon_next;

  always_comb begin
    mon_next           = mon_reg;
    mon_next.s1        = clk_pin_in;
    mon_next.s2        = mon_reg.s1;
    mon_next.prev      = mon_reg.s2;
    mon_next.edge_seen = mon_reg.s2 & ~mon_reg.prev;
    if (mon_next.edge_seen) begin
      mon_next.idle_cnt = 8'h00;
      mon_next.alive    = 1'b1;
    end else if (mon_reg.idle_cnt == 8'(`CBS_CLK_TIMEOUT_CYC - 1)) begin
      // a stopped reference drops the clock source within the timeout
      mon_next.alive = 1'b0;
    end else begin
      mon_next.idle_cnt = mon_reg.idle_cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  assign edge_out  = mon_reg.edge_seen;
  assign alive_out = mon_reg.alive;
endmodule : cbs_clk_monitor

// file: rtl/cbs_bringup.sv
`timescale 1ns/1ns
`include "cbs_params.svh"
// Function
// - standby one: selected clock source (bypass pin, locked pll or link clock) is good, logic clock stays gated
// - standby two: logic clock runs, all registers reachable, blocks off
// - idle: all blocks on except sequencer; capture starts when enabled
// - running: capture continuously in configured shutter and master/slave mode
// - parallel mode bypasses pll, clocking from the pll clock pin
// - address 2 selects mono/color and serial/parallel output
// - device starts pll and flags lock; host polls flag before phase two
// - low power standby keeps only clock registers reachable
module cbs_bringup
  import cbs_pkg::*;
(
  input  wire logic   clock_in,
  input  wire logic   rst_in,
  input  wire logic   clk_pll_in,
  input  wire logic   link_clk_in,
  input  wire logic   spi_sck_in,
  input  wire logic   spi_cs_n_in,
  input  wire logic   spi_mosi_in,
  input  wire logic   trigger_in,
  output logic        spi_miso_out,
  output logic        spi_miso_oe_out,
  output cbs_state_t  state_out,
  output logic        pll_locked_out,
  output logic        logic_clk_en_out,
  output logic        blocks_en_out,
  output logic        sequencer_en_out,
  output logic        color_out,
  output logic        parallel_mode_out,
  output logic        out_8bit_out,
  output cbs_shutter_t shutter_mode_out,
  output logic        frame_start_out
);
  cbs_main_t m_reg;
  cbs_main_t m_next;

  logic pll_edge;
  logic pll_alive;
  logic link_alive;
  logic bypass;
  logic pll_on;
  logic src_ok;
  logic sck_rise;
  logic sck_fall;
  logic trig_rise;
  logic cs_active;
  logic wr_commit;
  logic [8:0]  wr_addr;
  logic [15:0] wr_data;

  cbs_clk_monitor u_pll_mon (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .clk_pin_in (clk_pll_in),
    .edge_out   (pll_edge),
    .alive_out  (pll_alive)
  );

  cbs_clk_monitor u_link_mon (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .clk_pin_in (link_clk_in),
    .edge_out   (),
    .alive_out  (link_alive)
  );

  // clock registers stay reachable without the logic clock
  function automatic logic clock_reg(input logic [8:0] a);
    clock_reg = (a == `CBS_ADDR_COLOR)      || (a == `CBS_ADDR_PLL_SRST) ||
                (a == `CBS_ADDR_CG_SRST)    || (a == `CBS_ADDR_PLL_EN)   ||
                (a == `CBS_ADDR_PLL_CFG)    || (a == `CBS_ADDR_LINK_CLK) ||
                (a == `CBS_ADDR_LOCK_STAT)  || (a == `CBS_ADDR_LOCK_CFG_A) ||
                (a == `CBS_ADDR_LOCK_CFG_B) || (a == `CBS_ADDR_CLK_MGMT);
  endfunction : clock_reg

  function automatic logic [15:0] read_reg(input cbs_main_t s,
                                           input logic [8:0] a);
    read_reg = 16'h0000;
    case (a)
      `CBS_ADDR_COLOR:      read_reg = s.regs.color;
      `CBS_ADDR_PLL_SRST:   read_reg = s.regs.pll_srst;
      `CBS_ADDR_CG_SRST:    read_reg = s.regs.cg_srst;
      `CBS_ADDR_PLL_EN:     read_reg = s.regs.pll_en;
      `CBS_ADDR_PLL_CFG:    read_reg = s.regs.pll_cfg;
      `CBS_ADDR_LINK_CLK:   read_reg = s.regs.link_clk;
      `CBS_ADDR_LOCK_STAT:  read_reg = {15'h0000, s.locked};
      `CBS_ADDR_LOCK_CFG_A: read_reg = s.regs.lock_a;
      `CBS_ADDR_LOCK_CFG_B: read_reg = s.regs.lock_b;
      `CBS_ADDR_CLK_MGMT:   read_reg = s.regs.clk_mgmt;
      `CBS_ADDR_BLK_EN:     read_reg = s.regs.blk_en;
      `CBS_ADDR_SEQ_CTRL:   read_reg = s.regs.seq_ctrl;
      `CBS_ADDR_STATE:      read_reg = {11'h000, s.state};
      default:              read_reg = 16'h0000;
    endcase
    if (!s.logic_clk && !clock_reg(a)) begin
      read_reg = 16'h0000;
    end
  endfunction : read_reg

  always_comb begin
    sck_rise  = m_reg.s2.sck & ~m_reg.prev.sck;
    sck_fall  = ~m_reg.s2.sck & m_reg.prev.sck;
    trig_rise = m_reg.s2.trig & ~m_reg.prev.trig;
    cs_active = ~m_reg.s2.cs_n;
    wr_addr   = m_reg.shift[24:16];
    wr_data   = {m_reg.shift[14:0], m_reg.s2.mosi};
    wr_commit = cs_active && sck_rise && m_reg.bit_cnt == `CBS_LAST_BIT &&
                m_reg.shift[15] &&
                (m_reg.logic_clk || clock_reg(wr_addr));
    // parallel output always runs off the pll clock pin directly
    bypass = m_reg.regs.color[`CBS_PARALLEL_BIT] ||
             m_reg.regs.pll_en == `CBS_PLL_BYPASS_VAL;
    pll_on = !bypass && !m_reg.regs.pll_srst[0] &&
             (m_reg.regs.pll_en & `CBS_PLL_ON_MASK) == `CBS_PLL_ON_MASK;
    if (bypass) begin
      src_ok = pll_alive;
    end else if (pll_on) begin
      src_ok = m_reg.locked;
    end else begin
      src_ok = m_reg.regs.link_clk[`CBS_LINK_CLK_BIT] && link_alive;
    end
  end

  always_comb begin
    m_next             = m_reg;
    m_next.s1          = '{spi_sck_in, spi_cs_n_in, spi_mosi_in, trigger_in};
    m_next.s2          = m_reg.s1;
    m_next.prev        = m_reg.s2;
    m_next.frame_pulse = 1'b0;

    // serial register port: 9 address bits, write flag, 16 data bits
    if (!cs_active) begin
      m_next.bit_cnt = 5'd0;
      m_next.miso_oe = 1'b0;
    end else if (sck_rise) begin
      m_next.shift   = {m_reg.shift[23:0], m_reg.s2.mosi};
      m_next.bit_cnt = m_reg.bit_cnt + 5'd1;
      if (m_reg.bit_cnt == `CBS_WR_FLAG_BIT && !m_reg.s2.mosi) begin
        m_next.tx      = read_reg(m_reg, m_reg.shift[8:0]);
        m_next.miso_oe = 1'b1;
      end
      if (m_reg.bit_cnt == `CBS_LAST_BIT) begin
        m_next.bit_cnt = 5'd0;
      end
    end else if (sck_fall && m_reg.bit_cnt >= `CBS_FIRST_DATA_BIT) begin
      m_next.tx = {m_reg.tx[14:0], 1'b0};
    end

    if (wr_commit) begin
      case (wr_addr)
        `CBS_ADDR_COLOR:      m_next.regs.color    = wr_data;
        `CBS_ADDR_PLL_SRST:   m_next.regs.pll_srst = wr_data;
        `CBS_ADDR_CG_SRST:    m_next.regs.cg_srst  = wr_data;
        `CBS_ADDR_PLL_EN:     m_next.regs.pll_en   = wr_data;
        `CBS_ADDR_PLL_CFG:    m_next.regs.pll_cfg  = wr_data;
        `CBS_ADDR_LINK_CLK:   m_next.regs.link_clk = wr_data;
        `CBS_ADDR_LOCK_CFG_A: m_next.regs.lock_a   = wr_data;
        `CBS_ADDR_LOCK_CFG_B: m_next.regs.lock_b   = wr_data;
        `CBS_ADDR_CLK_MGMT:   m_next.regs.clk_mgmt = wr_data;
        `CBS_ADDR_BLK_EN:     m_next.regs.blk_en   = wr_data;
        `CBS_ADDR_SEQ_CTRL:   m_next.regs.seq_ctrl = wr_data;
        default: ;
      endcase
    end

    // lock detector counts reference edges once the pll is released
    if (!pll_on || !pll_alive) begin
      m_next.lock_cnt = 7'd0;
      m_next.locked   = 1'b0;
    end else if (pll_edge && !m_reg.locked) begin
      m_next.lock_cnt = m_reg.lock_cnt + 7'd1;
      if (m_reg.lock_cnt == 7'(`CBS_LOCK_EDGES - 1)) begin
        m_next.locked = 1'b1;
      end
    end

    m_next.logic_clk = src_ok && !m_reg.regs.cg_srst[0] &&
                       m_reg.regs.clk_mgmt[`CBS_LOGIC_CLK_BIT];
    m_next.blocks    = m_next.logic_clk &&
                       m_reg.regs.blk_en[`CBS_BLK_EN_BIT];
    m_next.seq       = m_next.blocks &&
                       m_reg.regs.seq_ctrl[`CBS_SEQ_EN_BIT];

    case (1'b1)
      m_next.seq:       m_next.state = ST_RUN;
      m_next.blocks:    m_next.state = ST_IDLE;
      m_next.logic_clk: m_next.state = ST_SB2;
      src_ok:           m_next.state = ST_SB1;
      default:          m_next.state = ST_LOWPWR;
    endcase

    // master modes free-run frames; slave modes frame on each trigger rise
    if (!m_reg.seq) begin
      m_next.frame_cnt = 9'd0;
    end else if (m_reg.regs.seq_ctrl[`CBS_SLAVE_BIT]) begin
      m_next.frame_pulse = trig_rise;
    end else if (m_reg.frame_cnt == 9'(`CBS_FRAME_CYC - 1)) begin
      // wrap only rearms; the zero count gives the one pulse per period
      m_next.frame_cnt   = 9'd0;
    end else begin
      if (m_reg.frame_cnt == 9'd0) begin
        m_next.frame_pulse = 1'b1;
      end
      m_next.frame_cnt = m_reg.frame_cnt + 9'd1;
    end
  end


  // pins park at idle levels so reset leaves no false edge or select
  localparam cbs_pins_t PINS_IDLE = 4'h4;
  localparam cbs_main_t MAIN_RST  = {{3{PINS_IDLE}}, 249'h0};

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      m_reg <= MAIN_RST;
    end else begin
      m_reg <= m_next;
    end
  end

  assign spi_miso_out      = m_reg.tx[15];
  assign spi_miso_oe_out   = m_reg.miso_oe;
  assign state_out         = m_reg.state;
  assign pll_locked_out    = m_reg.locked;
  assign logic_clk_en_out  = m_reg.logic_clk;
  assign blocks_en_out     = m_reg.blocks;
  assign sequencer_en_out  = m_reg.seq;
  assign color_out         = m_reg.regs.color[`CBS_COLOR_BIT];
  assign parallel_mode_out = m_reg.regs.color[`CBS_PARALLEL_BIT];
  assign out_8bit_out      = m_reg.regs.clk_mgmt[`CBS_8BIT_BIT];
  assign shutter_mode_out  =
    cbs_shutter_t'(m_reg.regs.seq_ctrl[`CBS_SHUTTER_LSB +: 2]);
  assign frame_start_out   = m_reg.frame_pulse;

  localparam int FRAME_MAX = 260;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_color_write;
    wr_commit && wr_addr == `CBS_ADDR_COLOR;
  endsequence

  sequence s_seq_write_blocked;
    cs_active && sck_rise && m_reg.bit_cnt == `CBS_LAST_BIT &&
    m_reg.shift[15] && !m_reg.logic_clk &&
    (wr_addr == `CBS_ADDR_SEQ_CTRL || wr_addr == `CBS_ADDR_BLK_EN);
  endsequence

  a_standby_one_gate: assert property (
    state_out == ST_SB1 |-> !logic_clk_en_out && !blocks_en_out)
    else $error("logic clock running in first standby");
  a_standby_two_regs: assert property (
    state_out == ST_SB2 |-> logic_clk_en_out && !blocks_en_out &&
                           !sequencer_en_out)
    else $error("blocks enabled in second standby");
  a_idle_seq_off: assert property (
    state_out == ST_IDLE |-> blocks_en_out && !sequencer_en_out)
    else $error("idle state inconsistent with enables");
  a_run_frame_rate: assert property (
    sequencer_en_out && !m_reg.regs.seq_ctrl[`CBS_SLAVE_BIT] &&
    $stable(m_reg.regs.seq_ctrl) |-> ##[0:FRAME_MAX] frame_start_out ||
    !sequencer_en_out || m_reg.regs.seq_ctrl[`CBS_SLAVE_BIT])
    else $error("no frame start while running in master mode");
  a_frame_single: assert property (
    frame_start_out && !m_reg.regs.seq_ctrl[`CBS_SLAVE_BIT] |=>
    !frame_start_out)
    else $error("master frame start lasted more than one cycle");
  a_slave_trigger: assert property (
    sequencer_en_out && m_reg.regs.seq_ctrl[`CBS_SLAVE_BIT] && trig_rise
    |=> frame_start_out)
    else $error("slave frame start missing after trigger");
  a_bypass_no_pll: assert property (
    parallel_mode_out |-> !pll_locked_out)
    else $error("pll lock reported in bypass mode");
  a_color_select: assert property (
    s_color_write |=> color_out == $past(wr_data[`CBS_COLOR_BIT]) &&
    parallel_mode_out == $past(wr_data[`CBS_PARALLEL_BIT]))
    else $error("color selection not taken from write");
  a_lock_flag_cause: assert property (
    $rose(pll_locked_out) |-> $past(pll_on) &&
    $past(m_reg.lock_cnt) == 7'(`CBS_LOCK_EDGES - 1))
    else $error("lock flag set without full edge count");
  a_lowpwr_subset: assert property (
    s_seq_write_blocked |=> $stable(m_reg.regs.seq_ctrl) &&
    $stable(m_reg.regs.blk_en))
    else $error("sequencer write accepted without logic clock");
endmodule : cbs_bringup

// file: bench/cbs_host_model.sv
`timescale 1ns/1ns
module cbs_host_model (
  input  wire logic clock_in,
  input  wire logic miso_in,
  output logic      rst_out,
  output logic      ref_clk_out,
  output logic      link_clk_out,
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  logic ref_run;
  logic link_run;

  initial begin
    {ref_run, link_run, ref_clk_out, link_clk_out} = 4'h8;
    {rst_out, sck_out, cs_n_out, mosi_out} = 4'ha;
    repeat (2) @(negedge clock_in);
    rst_out = 1'b0;
  end
  // a stopped reference parks low
  always begin
    #62 ref_clk_out = ref_run;
    #63 ref_clk_out = 1'b0;
  end
  always begin
    #30 link_clk_out = link_run;
    #62 link_clk_out = 1'b0;
    #33;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc

  // whole frame before the next one
  task automatic xfer(input logic [8:0] a, input logic w,
                      input logic [15:0] d, output logic [15:0] q);
    logic [25:0] f;
    f = {a, w, d};
    q = 16'h0000;
    cyc(1);
    cs_n_out = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      mosi_out = f[i];
      cyc(6);
      sck_out = 1'b1;
      if (i < 16) q[i] = miso_in;
      cyc(6);
      sck_out = 1'b0;
    end
    cyc(6);
    mosi_out = ~mosi_out;
    cs_n_out = 1'b1;
    cyc(6);
  endtask : xfer

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  // reference settles before reset is let go
  task automatic power_up(input int v);
    ref_run = !(v == 1 || v == 3);
    link_run = (v == 1 || v == 3);
    cyc(20);
    rst_out = 1'b1;
    cyc(2);
    rst_out = 1'b0;
    cyc(1250);
  endtask : power_up

  // v: 0 8b pll, 1 8b link, 2 10b pll, 3 10b link, 4 parallel
  task automatic phase1(input int v, input logic col);
    logic [15:0] q;
    int          n;
    wr(9'h002, {14'h0, v == 4, col});
    wr(9'h020, v == 1 ? 16'h2008 : v == 3 ? 16'h2000 :
               v == 2 ? 16'h2004 : 16'h200c);
    wr(9'h014, {15'h0, v == 1 || v == 3});
    if (v == 0 || v == 2) begin
      wr(9'h011, v == 0 ? 16'h210f : 16'h2113);
      wr(9'h01a, v == 0 ? 16'h1180 : 16'h2280);
      wr(9'h01b, v == 0 ? 16'hccbc : 16'h3d2d);
      wr(9'h008, 16'h0000);
      wr(9'h010, 16'h0003);
      n = 0;
      q = 16'h0000;
      while (q[0] !== 1'b1 && n < 40) begin
        xfer(9'h018, 1'b0, 16'h0000, q);
        n++;
      end
    end else if (v == 4) begin
      wr(9'h010, 16'h0007);
    end
  endtask : phase1

  task automatic phase2(input int v);
    wr(9'h009, 16'h0000);
    wr(9'h020, v == 1 ? 16'h200a : v == 2 ? 16'h2006 :
               v == 3 ? 16'h2002 : 16'h200e);
  endtask : phase2
endmodule : cbs_host_model

// file: bench/tb.sv
`timescale 1ns/1ns
module tb
  import cbs_pkg::*;
;
  logic         clock_in;
  logic         trig;
  logic         r_en;
  logic [31:0]  r;
  logic [15:0]  rd_val;
  logic [15:0]  exp_q[$];
  int           error_cnt;
  int           n_checks;
  int           cyc_cnt = 0;
  int           fr_n = 0;
  int           fr_0;
  event         rd_ev;
  logic         rst_in;
  logic         ref_clk;
  logic         link_clk;
  logic         sck;
  logic         cs_n;
  logic         mosi;
  logic         miso;
  logic         miso_oe;
  cbs_state_t   st;
  cbs_shutter_t shm;
  logic         locked;
  logic         lclk;
  logic         blk;
  logic         seq;
  logic         color;
  logic         par;
  logic         b8;
  logic         frame;

  cbs_host_model host (
    .clock_in    (clock_in),
    .miso_in     (miso),
    .rst_out     (rst_in),
    .ref_clk_out (ref_clk),
    .link_clk_out(link_clk),
    .sck_out     (sck),
    .cs_n_out    (cs_n),
    .mosi_out    (mosi)
  );

  cbs_bringup dut (
    .clock_in         (clock_in),
    .rst_in           (rst_in),
    .clk_pll_in       (ref_clk),
    .link_clk_in      (link_clk),
    .spi_sck_in       (sck),
    .spi_cs_n_in      (cs_n),
    .spi_mosi_in      (mosi),
    .trigger_in       (trig),
    .spi_miso_out     (miso),
    .spi_miso_oe_out  (miso_oe),
    .state_out        (st),
    .pll_locked_out   (locked),
    .logic_clk_en_out (lclk),
    .blocks_en_out    (blk),
    .sequencer_en_out (seq),
    .color_out        (color),
    .parallel_mode_out(par),
    .out_8bit_out     (b8),
    .shutter_mode_out (shm),
    .frame_start_out  (frame)
  );

  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd_chk(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] q;
    exp_q.push_back(e);
    fork
      host.xfer(a, 1'b0, 16'h0000, q);
      begin
        host.cyc(200);
        chk("miso oe", 16'h0001, 16'(miso_oe));
      end
    join
    chk("miso oe", 16'h0000, 16'(miso_oe));
    rd_val = q;
    -> rd_ev;
  endtask : rd_chk

  initial forever begin
    @(rd_ev);
    chk("read data", exp_q.pop_front(), rd_val);
  end

  always @(posedge clock_in) begin
    if (frame === 1'b1) fr_n <= fr_n + 1;
    cyc_cnt <= cyc_cnt + 1;
    // whole run needs about 40k cycles
    if (cyc_cnt == 90000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    {trig, error_cnt, n_checks} = '0;
    void'($urandom(29974));
    for (int v = 0; v < 5; v++) begin
      r = $urandom();
      r_en = (v == 0 || v == 2);
      host.power_up(v);
      chk("state", 16'(ST_LOWPWR), 16'(st));
      host.wr(9'h022, 16'h0001);
      rd_chk(9'h022, 16'h0000);
      host.phase1(v, r[0]);
      host.cyc(200);
      chk("state", 16'(ST_SB1), 16'(st));
      chk("logic clk", 16'h0000, 16'(lclk));
      chk("locked", 16'(r_en), 16'(locked));
      rd_chk(9'h018, 16'(r_en));
      chk("color", 16'(r[0]), 16'(color));
      chk("parallel", 16'(v == 4), 16'(par));
      rd_chk(9'h002, {14'h0, v == 4, r[0]});
      host.phase2(v);
      host.cyc(10);
      chk("state", 16'(ST_SB2), 16'(st));
      chk("logic clk", 16'h0001, 16'(lclk));
      chk("blocks", 16'h0000, 16'(blk));
      chk("8bit", 16'(v < 2 || v == 4), 16'(b8));
      host.wr(9'h0c0, {13'h0, r[2:1], 1'b0});
      rd_chk(9'h0c0, {13'h0, r[2:1], 1'b0});
      host.wr(9'h022, 16'h0001);
      host.cyc(10);
      chk("state", 16'(ST_IDLE), 16'(st));
      chk("blocks", 16'h0001, 16'(blk));
      chk("sequencer", 16'h0000, 16'(seq));
      rd_chk(9'h0c1, 16'(ST_IDLE));
      if (v == 4) begin
        fr_0 = fr_n;
        host.wr(9'h0c0, {13'h0, r[2:1], 1'b1});
        host.cyc(400);
        chk("state", 16'(ST_RUN), 16'(st));
        chk("sequencer", 16'h0001, 16'(seq));
        chk("shutter", 16'(r[2:1]), 16'(shm));
        chk("frames", 16'h0002, 16'(fr_n - fr_0));
        host.wr(9'h0c0, {12'h0, 1'b1, r[2:1], 1'b1});
        host.cyc(300);
        fr_0 = fr_n;
        repeat (3) begin
          trig = 1'b1;
          host.cyc(10);
          trig = 1'b0;
          host.cyc(20);
        end
        chk("frames", 16'h0003, 16'(fr_n - fr_0));
      end
    end
    wrap_up();
  end
endmodule : tb
